/* File: common/rx_port_if.sv */
// link between the sending party and the cell receive port
`timescale 1ns/100ps
`default_nettype none
interface rx_port_if;
  import rx_port_pkg::*;
  logic rx_port_cell_space;
  logic rx_port_enable_in;
  port_byte_t rx_port_byte_bus;
  logic rx_port_parity_in;
  logic rx_port_cell_start;
  modport device (
    output rx_port_cell_space,
    input rx_port_enable_in,
    input rx_port_byte_bus,
    input rx_port_parity_in,
    input rx_port_cell_start
  );
  modport sender (
    input rx_port_cell_space,
    output rx_port_enable_in,
    output rx_port_byte_bus,
    output rx_port_parity_in,
    output rx_port_cell_start
  );
endinterface : rx_port_if
`default_nettype wire

/* File: common/rx_port_pkg.sv */
// shared constants and types for the cell receive port
package rx_port_pkg;
  localparam int unsigned byte_w = 8;
  localparam int unsigned cell_bytes = 53;
  localparam logic [5:0] cell_last = 6'h34;
  localparam logic [5:0] count_rst = 6'h00;
  localparam logic [7:0] byte_rst = 8'h00;
  localparam int unsigned buf_depth = 2;
  typedef enum logic {mode_phy, mode_atm} port_mode_t;
  typedef logic [byte_w-1:0] port_byte_t;
endpackage : rx_port_pkg

/* File: design/cell_rx_port.sv */
// device end: receive port with parity check and two-entry buffer
`timescale 1ns/100ps
`default_nettype none
module cell_rx_port (
  input wire logic clock,
  input wire logic rstn,
  input wire rx_port_pkg::port_mode_t mode,
  rx_port_if.device link,
  output logic rx_port_parity_error,
  output logic out_valid,
  output rx_port_pkg::port_byte_t out_byte,
  output logic out_first,
  input wire logic out_ready
);
  import rx_port_pkg::*;

  // timing in short, one port clock for every register:
  //   phy: a byte stands in the cycle with enable low and is captured at
  //   the edge that closes that cycle; cell space falls as soon as the
  //   buffer holds a byte, and the one trailing byte still in flight fits
  //   in the second entry
  //   atm: read enable (cell space low) stands for one cycle, the byte
  //   follows in the next cycle, and a new read waits for an empty buffer
  //   parity error is a one-cycle level for the byte of the cycle before
  //   mode: a role change waits for an empty buffer and no read in
  //   flight, then cell space jumps to the idle level of the new role
  //   limitation: atm throughput is one byte per three cycles at best

  // role as the port sees it; taken over only while nothing is moving
  port_mode_t mode_r, mode_nxt;
  logic mode_idle;

  // atm read enable and its delayed copy
  logic rd_r, rd_nxt;
  logic rd_d_r, rd_d_nxt;

  // high in a cycle whose byte bus must be captured
  logic byte_in;

  // cell space pin register
  logic space_r, space_nxt;

  // parity of the byte on the bus and the registered error flag
  logic odd_ok;
  logic perr_r, perr_nxt;

  // two-entry buffer, start flag kept above the byte
  logic [8:0] ent_r [buf_depth];
  logic [8:0] ent_nxt [buf_depth];
  logic [1:0] cnt_r, cnt_nxt;
  logic pop;

  // head-valid flag kept in a flop so the output is registered
  logic valid_r, valid_nxt;

  // capture qualifier: enable low in phy, one cycle after read in atm
  always_comb begin
    // a byte outside these cycles is ignored, whatever the bus shows
    if (mode_r == mode_phy) begin
      byte_in = !link.rx_port_enable_in;
    end else begin
      byte_in = rd_d_r;
    end
  end

  // buffer next state; a pop frees the head before the new byte lands,
  // so a full buffer that is drained in the same cycle still takes it
  always_comb begin
    pop = valid_r && out_ready;
    ent_nxt = ent_r;
    cnt_nxt = cnt_r;
    if (pop) begin
      ent_nxt[0] = ent_r[1];
      cnt_nxt = cnt_nxt - 2'h1;
    end
    // the handshakes keep at most two bytes in flight, so no byte is lost
    if (byte_in && cnt_nxt < 2'h2) begin
      ent_nxt[cnt_nxt[0]] = {link.rx_port_cell_start,
                             link.rx_port_byte_bus};
      cnt_nxt = cnt_nxt + 2'h1;
    end
    // valid follows the count at the same edge, like the entries
    valid_nxt = (cnt_nxt != 2'h0);
  end

  // buffer registers; entries clear on reset so the outputs start
  // from a known value
  always_ff @(posedge clock) begin
    if (!rstn) begin
      cnt_r <= 2'h0;
      valid_r <= 1'b0;
      ent_r[0] <= 9'h000;
      ent_r[1] <= 9'h000;
    end else begin
      cnt_r <= cnt_nxt;
      valid_r <= valid_nxt;
      ent_r <= ent_nxt;
    end
  end

  // atm reads: one at a time, only into an empty buffer with a cell
  // available; the delayed copy marks the cycle the byte is on the bus
  always_comb begin
    rd_nxt = 1'b0;
    rd_d_nxt = rd_r;
    // no read while a role change is being taken over
    if (mode_r == mode_atm && mode_nxt == mode_atm) begin
      rd_nxt = link.rx_port_enable_in && cnt_nxt == 2'h0 && !rd_r &&
               !rd_d_r;
    end
  end

  // read pipeline registers; nothing is in flight after reset,
  // so the first read waits for cell available
  always_ff @(posedge clock) begin
    if (!rstn) begin
      rd_r <= 1'b0;
      rd_d_r <= 1'b0;
    end else begin
      rd_r <= rd_nxt;
      rd_d_r <= rd_d_nxt;
    end
  end

  // cell space: room indication in phy, active-low read enable in atm;
  // registered so the far end sees a clean level for the whole cycle
  always_comb begin
    if (mode_r == mode_phy) begin
      space_nxt = (cnt_nxt == 2'h0);
    end else begin
      space_nxt = !rd_nxt;
    end
    // a role change puts the pin at the idle level of the new role
    if (mode_nxt != mode_r) begin
      space_nxt = (mode_nxt == mode_atm);
    end
  end

  // cell space register; low in reset so a phy sender waits, though
  // an atm sender takes that low level as a read enable during reset
  always_ff @(posedge clock) begin
    if (!rstn) begin
      space_r <= 1'b0;
    end else begin
      space_r <= space_nxt;
    end
  end

  // odd parity over the byte and its parity bit; only a captured
  // byte can raise the flag, idle bus noise is not reported
  always_comb begin
    odd_ok = ^{link.rx_port_parity_in,
               link.rx_port_byte_bus};
    perr_nxt = byte_in && !odd_ok;
  end

  // parity flag register; it stands for one cycle per bad byte
  // and is never held, the reader must watch every cycle
  always_ff @(posedge clock) begin
    if (!rstn) begin
      perr_r <= 1'b0;
    end else begin
      perr_r <= perr_nxt;
    end
  end

  // role takeover only when the buffer is empty and no read is pending,
  // so a byte is never judged under the wrong role
  always_comb begin
    // a byte on the bus or a read in flight holds the old role
    mode_idle = cnt_r == 2'h0 && !byte_in && !rd_r && !rd_d_r;
    if (mode_idle) begin
      mode_nxt = mode;
    end else begin
      mode_nxt = mode_r;
    end
  end

  // role register; phy after reset, the new role is taken on the
  // first idle cycle after release
  always_ff @(posedge clock) begin
    if (!rstn) begin
      mode_r <= mode_phy;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // outputs straight from flops: the head entry, its valid flag,
  // the cell space pin and the parity flag; no logic stands between
  // a register and a pin
  assign link.rx_port_cell_space = space_r;
  assign rx_port_parity_error = perr_r;
  assign out_valid = valid_r;
  assign out_byte = ent_r[0][7:0];
  assign out_first = ent_r[0][8];
endmodule : cell_rx_port
`default_nettype wire

/* File: design/cell_sender.sv */
// far end: sends 53-byte cells into the receive port in either role
`timescale 1ns/100ps
`default_nettype none
module cell_sender (
  input wire logic clock,
  input wire logic rstn,
  input wire rx_port_pkg::port_mode_t mode,
  input wire logic src_valid,
  input wire rx_port_pkg::port_byte_t src_byte,
  input wire logic src_first,
  output logic src_ready,
  rx_port_if.sender link
);
  import rx_port_pkg::*;
  logic en_r, en_nxt, soc_r, soc_nxt, par_r, par_nxt;
  port_byte_t dat_r, dat_nxt;
  logic [5:0] cnt_r, cnt_nxt;
  logic take;
  // phy role: send only with cell space; atm role: read enable pulls
  always_comb begin
    take = 1'b0;
    if (mode == mode_phy) begin
      // every byte waits for cell space: the port holds two bytes only
      take = src_valid && link.rx_port_cell_space;
    end else begin
      take = src_valid && !link.rx_port_cell_space;
    end
    src_ready = take;
    en_nxt = (mode == mode_phy) ? !take : 1'b1;
    dat_nxt = take ? src_byte : dat_r;
    par_nxt = take ? ~^src_byte : par_r;
    soc_nxt = take && src_first;
    cnt_nxt = cnt_r;
    if (take) begin
      cnt_nxt = (cnt_r == cell_last) ? count_rst : cnt_r + 6'h01;
    end
    if (mode == mode_atm) begin
      en_nxt = src_valid;
    end
  end
  // link outputs registered; one clock shared with the port
  always_ff @(posedge clock) begin
    if (!rstn) begin
      en_r <= 1'b1;
      soc_r <= 1'b0;
      par_r <= 1'b1;
      dat_r <= byte_rst;
      cnt_r <= count_rst;
    end else begin
      en_r <= en_nxt;
      soc_r <= soc_nxt;
      par_r <= par_nxt;
      dat_r <= dat_nxt;
      cnt_r <= cnt_nxt;
    end
  end
  assign link.rx_port_enable_in = en_r;
  assign link.rx_port_byte_bus = dat_r;
  assign link.rx_port_parity_in = par_r;
  assign link.rx_port_cell_start = soc_r;
endmodule : cell_sender
`default_nettype wire

/* File: sim/cell_reassembly_rx_port_tb_top.sv */
// bench: both port ends joined, random cells sent in both roles
`timescale 1ns/100ps
`default_nettype none
module cell_reassembly_rx_port_tb_top;
  import rx_port_pkg::*;
  logic clock, rstn, src_valid, src_first, src_ready, run;
  logic rx_port_parity_error, out_valid, out_first, out_ready;
  port_mode_t mode;
  port_byte_t src_byte, out_byte;
  logic [8:0] exp_q[$];
  int mismatches, checks, idx, sent;
  rx_port_if link ();
  cell_sender cell_sender_inst (.clock, .rstn, .mode, .src_valid,
    .src_byte, .src_first, .src_ready, .link);
  cell_rx_port cell_rx_port_inst (.clock, .rstn, .mode, .link,
    .rx_port_parity_error, .out_valid, .out_byte, .out_first, .out_ready);
  cell_rx_port_asserts cell_rx_port_asserts_inst (.clock, .rstn, .mode,
    .rx_port_cell_space(link.rx_port_cell_space),
    .rx_port_enable_in(link.rx_port_enable_in),
    .rx_port_byte_bus(link.rx_port_byte_bus),
    .rx_port_parity_in(link.rx_port_parity_in),
    .rx_port_cell_start(link.rx_port_cell_start), .rx_port_parity_error);
  task automatic chk(input logic ok);
    checks++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("ERROR %0t ns check failed", $time);
    end
  endtask
  task automatic report_and_stop;
    if (mismatches == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // source side: gaps at random, a started cell always runs to its end
  always @(posedge clock) begin
    if (src_valid && src_ready) begin
      exp_q.push_back({src_first, src_byte});
      sent++;
      idx = (idx + 1) % cell_bytes;
    end
    if (!src_valid || src_ready) begin
      src_valid <= (run || idx != 0) && ($urandom % 4 != 0);
      src_byte <= (sent % 5 == 0) ? byte_rst : 8'($urandom);
      src_first <= idx == 0;
    end
  end
  // sink side: random stalls fill the buffer so the sender must wait
  always @(posedge clock) begin
    out_ready <= $urandom % 3 != 0;
    if (rstn && out_valid && out_ready)
      chk({out_first, out_byte} === exp_q.pop_front());
    if (rstn) chk(rx_port_parity_error === 1'b0);
  end
  initial begin
    void'($urandom(32'h64a8));
    {rstn, run, src_valid, src_first, out_ready} = 5'h00;
    src_byte = byte_rst;
    mode = mode_phy;
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    repeat (2) @(posedge clock);
    for (int m = 0; m < 2; m++) begin
      mode <= port_mode_t'(m);
      @(posedge clock);
      run <= 1'b1;
      for (int i = 0; i < 4000 && sent < (m + 1) * 3 * cell_bytes; i++)
        @(posedge clock);
      run <= 1'b0;
      for (int i = 0; i < 800 && (exp_q.size() > 0 || idx != 0); i++)
        @(posedge clock);
      chk(exp_q.size() == 0 && sent >= (m + 1) * 3 * cell_bytes);
    end
    report_and_stop;
  end
  initial begin
    #100000;
    mismatches++;
    report_and_stop;
  end
endmodule // cell_reassembly_rx_port_tb_top
`default_nettype wire

/* File: sim/cell_rx_port_asserts.sv */
// checker on the link signals between the two port ends
`timescale 1ns/100ps
`default_nettype none
module cell_rx_port_asserts (
  input wire logic clock,
  input wire logic rstn,
  input wire rx_port_pkg::port_mode_t mode,
  input wire logic rx_port_cell_space,
  input wire logic rx_port_enable_in,
  input wire rx_port_pkg::port_byte_t rx_port_byte_bus,
  input wire logic rx_port_parity_in,
  input wire logic rx_port_cell_start,
  input wire logic rx_port_parity_error
);
  import rx_port_pkg::*;
  // short names for the qualifying conditions of a transfer
  wire logic phy = mode == mode_phy;
  wire logic put = phy && !rx_port_enable_in;
  wire logic rd = mode == mode_atm && !rx_port_cell_space;
  wire logic odd = ^{rx_port_parity_in, rx_port_byte_bus};
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  property p_par_phy; put |-> odd; endproperty
  a_par_phy: assert property (p_par_phy) else $error("bad parity");
  property p_perr_phy; put |=> rx_port_parity_error == !$past(odd);
  endproperty
  a_perr_phy: assert property (p_perr_phy) else $error("perr");
  // atm data lands one cycle after the read enable, flag one later
  property p_perr_atm; rd ##1 1 |=> rx_port_parity_error == !$past(odd);
  endproperty
  a_perr_atm: assert property (p_perr_atm) else $error("perr");
  property p_rd_gap; rd |=> !rd; endproperty
  a_rd_gap: assert property (p_rd_gap) else $error("read pulse");
  property p_par_atm; rd |=> odd; endproperty
  a_par_atm: assert property (p_par_atm) else $error("atm parity");
  property p_soc; phy && rx_port_cell_start |-> !rx_port_enable_in;
  endproperty
  a_soc: assert property (p_soc) else $error("start flag");
endmodule // cell_rx_port_asserts
`default_nettype wire
